// ### include/timer8_pkg.sv
// constants for the 8-bit timer compare unit: register map, fields, resets
// assumes a 32-bit apb slave with 8-bit byte addresses
package timer8_pkg;
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CMP   = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_IRQEN = 8'h10;
    localparam logic [7:0] ADDR_PORT  = 8'h14;

    // control register fields
    localparam int CS_LSB    = 0;
    localparam int WGM_LSB   = 3;
    localparam int COM_LSB   = 5;
    localparam int FORCE_BIT = 7;
    // flag and enable bit positions
    localparam int OVF_BIT   = 0;
    localparam int CMP_BIT   = 1;
    localparam int GIE_BIT   = 2;
    // port register bits
    localparam int PDATA_BIT = 0;
    localparam int PDIR_BIT  = 1;
    localparam int OCBIT_BIT = 2;
    localparam int PIN_BIT   = 3;

    localparam logic [7:0]  COUNT_MAX    = 8'hff;
    localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [9:0]  PRESCALE_RST = 10'h000;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

    // prescale taps: low bits all ones once every 8, 64, 256, 1024 cycles
    localparam int DIV8_BITS    = 3;
    localparam int DIV64_BITS   = 6;
    localparam int DIV256_BITS  = 8;
    localparam int DIV1024_BITS = 10;

    typedef enum logic [2:0] {
        cs_stop     = 3'h0,
        cs_div1     = 3'h1,
        cs_div8     = 3'h2,
        cs_div64    = 3'h3,
        cs_div256   = 3'h4,
        cs_div1024  = 3'h5,
        cs_ext_fall = 3'h6,
        cs_ext_rise = 3'h7
    } clock_source_t;

    typedef enum logic [1:0] {
        wgm_normal    = 2'h0,
        wgm_phase_pwm = 2'h1,
        wgm_clear     = 2'h2,
        wgm_fast_pwm  = 2'h3
    } waveform_mode_t;

    typedef enum logic [1:0] {
        com_none   = 2'h0,
        com_toggle = 2'h1,
        com_clear  = 2'h2,
        com_set    = 2'h3
    } compare_action_t;
endpackage

// ### design/timer8_compare_normal_ctc.sv
// 8-bit timer/counter with one output compare unit, apb register access
// assumes apb master on clk_sys; irq acks come from same-clock interrupt logic
// Notes on behaviour
// - counter always compared to compare value; match sets flag on the timer tick
// - compare irq requested only when enable, global enable and flag all set
// - compare flag clears on irq service or on software writing one
// - pwm modes double buffer compare value, loaded at top; others bypass
// - cpu compare accesses reach buffer in pwm modes, active value otherwise
// - force strobe in non-pwm modes acts on output bit only, no flag or clear
// - counter write blocks every match on the next timer tick, even when stopped
// - output action field unbuffered; takes effect at the first match after write
// - output bit reset to zero, kept across waveform mode changes
// - nonzero action field puts output bit on pin; direction bit keeps direction
// - action zero leaves the output bit unchanged on matches in every mode
// - counting depends only on waveform mode, never on action field
// - mode 0 only increments, wraps from 0xff to 0x00, never cleared
// - normal mode sets overflow as count becomes zero; cleared by service or by software writing one
// - mode 2 clears counter on match, compare value acts as top
// - clear mode with compare below count runs to 0xff and wraps before a match
// - clear mode with action 1 toggles output on each match
// - prescale factors 1, 8, 64, 256 and 1024 form the timer tick
// - clear mode sets overflow when counter passes from max to zero
// - cpu count write wins over simultaneous count or clear
// - clock select zero stops counter, count stays readable and writable
// - counter maximum is 0xff, bottom is zero
// - mode 3 fast pwm, mode 1 phase-correct pwm, both double buffered
`timescale 1ns/1ps
module timer8_compare_normal_ctc
    import timer8_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        compare_irq_ack,
    input  wire logic        overflow_irq_ack,
    output logic             compare_irq_req,
    output logic             overflow_irq_req,
    input  wire logic        t0_pin_in,
    input  wire logic        oc_pin_in,
    output logic             oc_pin_out,
    output logic             oc_pin_oe_n
);
    clock_source_t   clock_source_select;
    waveform_mode_t  waveform_mode_select;
    compare_action_t compare_output_action;
    compare_action_t action_now;
    logic [7:0]      timer_count_value;
    logic [7:0]      compare_value_reg;
    logic [7:0]      compare_buffer;
    logic            compare_match_flag;
    logic            overflow_flag;
    logic            compare_irq_enable;
    logic            overflow_irq_enable;
    logic            global_irq_enable;
    logic            port_data;
    logic            compare_pin_direction_bit;
    logic            compare_output_bit;
    logic            count_down;
    logic            block_match;
    logic [9:0]      prescale;
    logic            t0_meta;
    logic            t0_sync;
    logic            t0_prev;
    logic            pin_meta;
    logic            pin_sync;
    logic            tick;
    logic            pwm;
    logic            match;
    logic            force_cmp;
    logic            wr;
    logic            wr_ctrl;
    logic            wr_count;
    logic            wr_cmp;
    logic            wr_flags;
    logic            up_now;
    logic [7:0]      next_count;
    logic            next_down;
    logic            ovf_event;
    logic            top_event;
    logic [31:0]     next_rdata;
    logic            next_err;

    function automatic logic is_pwm(input waveform_mode_t m);
        return (m == wgm_phase_pwm) || (m == wgm_fast_pwm);
    endfunction

    function automatic logic act_on(input compare_action_t a, input logic cur);
        unique case (a)
            com_none:   return cur;
            com_toggle: return ~cur;
            com_clear:  return 1'b0;
            com_set:    return 1'b1;
        endcase
    endfunction

    // writes land only at the access edge, pready is high there
    assign wr       = psel && penable && pwrite && pready;
    assign wr_ctrl  = wr && (paddr == ADDR_CTRL);
    assign wr_count = wr && (paddr == ADDR_COUNT);
    assign wr_cmp   = wr && (paddr == ADDR_CMP);
    assign wr_flags = wr && (paddr == ADDR_FLAGS);
    assign pwm      = is_pwm(waveform_mode_select);

    // synchronisers for the external count pin and the compare pin readback
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            t0_meta  <= 1'b0;
            t0_sync  <= 1'b0;
            t0_prev  <= 1'b0;
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            t0_meta  <= t0_pin_in;
            t0_sync  <= t0_meta;
            t0_prev  <= t0_sync;
            pin_meta <= oc_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // free-running prescaler; phase is not reset on a source change
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prescale <= PRESCALE_RST;
        end else begin
            prescale <= prescale + 10'h001;
        end
    end

    // external edges lag the pin by three clocks
    always_comb begin
        unique case (clock_source_select)
            cs_stop:     tick = 1'b0;
            cs_div1:     tick = 1'b1;
            cs_div8:     tick = &prescale[DIV8_BITS-1:0];
            cs_div64:    tick = &prescale[DIV64_BITS-1:0];
            cs_div256:   tick = &prescale[DIV256_BITS-1:0];
            cs_div1024:  tick = &prescale[DIV1024_BITS-1:0];
            cs_ext_fall: tick = t0_prev && !t0_sync;
            cs_ext_rise: tick = !t0_prev && t0_sync;
        endcase
    end

    // match seen while the count value stands, acted on at the tick ending it
    assign match = tick && (timer_count_value == compare_value_reg) && !block_match;

    // count sequence from the mode field alone
    always_comb begin
        next_count = timer_count_value;
        next_down  = 1'b0;
        ovf_event  = 1'b0;
        top_event  = 1'b0;
        up_now     = count_down ? (timer_count_value == COUNT_BOTTOM) : (timer_count_value != COUNT_MAX);
        if (tick) begin
            unique case (waveform_mode_select)
                wgm_normal, wgm_fast_pwm: begin
                    next_count = timer_count_value + 8'h01;
                    ovf_event  = (timer_count_value == COUNT_MAX);
                    top_event  = (timer_count_value == COUNT_MAX);
                end
                wgm_clear: begin
                    next_count = match ? COUNT_BOTTOM : timer_count_value + 8'h01;
                    ovf_event  = (timer_count_value == COUNT_MAX);
                end
                wgm_phase_pwm: begin
                    next_count = up_now ? timer_count_value + 8'h01 : timer_count_value - 8'h01;
                    next_down  = ~up_now;
                    ovf_event  = count_down && (next_count == COUNT_BOTTOM);
                    top_event  = (timer_count_value == COUNT_MAX);
                end
            endcase
        end else begin
            next_down = count_down;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            timer_count_value <= RESET_BYTE;
            count_down        <= 1'b0;
        end else begin
            if (wr_count) begin
                timer_count_value <= pwdata[7:0];
            end else begin
                timer_count_value <= next_count;
            end
            count_down <= next_down;
        end
    end

    // a count write arms the block until the next tick has gone by
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            block_match <= 1'b0;
        end else if (wr_count) begin
            block_match <= 1'b1;
        end else if (tick) begin
            block_match <= 1'b0;
        end
    end

    // compare value: buffered in pwm modes, direct otherwise
    // a pwm write waits in the buffer until the count reaches top
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            compare_value_reg <= RESET_BYTE;
            compare_buffer    <= RESET_BYTE;
        end else begin
            if (wr_cmp) begin
                compare_buffer <= pwdata[7:0];
            end
            if (wr_cmp && !pwm) begin
                compare_value_reg <= pwdata[7:0];
            end else if (pwm && top_event) begin
                compare_value_reg <= compare_buffer;
            end
        end
    end

    // control register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clock_source_select   <= cs_stop;
            waveform_mode_select  <= wgm_normal;
            compare_output_action <= com_none;
        end else if (wr_ctrl) begin
            clock_source_select   <= clock_source_t'(pwdata[CS_LSB +: 3]);
            waveform_mode_select  <= waveform_mode_t'(pwdata[WGM_LSB +: 2]);
            compare_output_action <= compare_action_t'(pwdata[COM_LSB +: 2]);
        end
    end

    // a force in the same write as a new action uses the new action
    assign action_now = wr_ctrl ? compare_action_t'(pwdata[COM_LSB +: 2]) : compare_output_action;
    assign force_cmp  = wr_ctrl && pwdata[FORCE_BIT] && !pwm;

    // output bit; mode changes leave it alone
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            compare_output_bit <= 1'b0;
        end else if (force_cmp || (match && !pwm)) begin
            compare_output_bit <= act_on(action_now, compare_output_bit);
        end else if (tick && compare_output_action[1]) begin
            // pwm modes; toggle action is treated as no action here
            if (waveform_mode_select == wgm_fast_pwm) begin
                if (top_event) begin
                    compare_output_bit <= ~compare_output_action[0];
                end else if (match) begin
                    compare_output_bit <= compare_output_action[0];
                end
            end else if (waveform_mode_select == wgm_phase_pwm && match) begin
                compare_output_bit <= count_down ^ compare_output_action[0];
            end
        end
    end

    // flags: hardware set wins over any clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            compare_match_flag <= 1'b0;
        end else if (match) begin
            compare_match_flag <= 1'b1;
        end else if ((wr_flags && pwdata[CMP_BIT]) || compare_irq_ack) begin
            compare_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            overflow_flag <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag <= 1'b1;
        end else if ((wr_flags && pwdata[OVF_BIT]) || overflow_irq_ack) begin
            overflow_flag <= 1'b0;
        end
    end

    // enables, port data and direction
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            overflow_irq_enable       <= 1'b0;
            compare_irq_enable        <= 1'b0;
            global_irq_enable         <= 1'b0;
            port_data                 <= 1'b0;
            compare_pin_direction_bit <= 1'b0;
        end else begin
            if (wr && paddr == ADDR_IRQEN) begin
                overflow_irq_enable <= pwdata[OVF_BIT];
                compare_irq_enable  <= pwdata[CMP_BIT];
                global_irq_enable   <= pwdata[GIE_BIT];
            end
            if (wr && paddr == ADDR_PORT) begin
                port_data                 <= pwdata[PDATA_BIT];
                compare_pin_direction_bit <= pwdata[PDIR_BIT];
            end
        end
    end

    // pin and interrupt outputs, one cycle behind their sources
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            oc_pin_out       <= 1'b0;
            oc_pin_oe_n      <= 1'b1;
            compare_irq_req  <= 1'b0;
            overflow_irq_req <= 1'b0;
        end else begin
            oc_pin_out       <= (compare_output_action != com_none) ? compare_output_bit : port_data;
            oc_pin_oe_n      <= ~compare_pin_direction_bit;
            compare_irq_req  <= compare_irq_enable && global_irq_enable && compare_match_flag;
            overflow_irq_req <= overflow_irq_enable && global_irq_enable && overflow_flag;
        end
    end

    // read mux; sampled in the setup cycle
    always_comb begin
        next_rdata = READ_ZERO;
        next_err   = 1'b0;
        unique case (paddr)
            ADDR_CTRL: begin
                next_rdata[CS_LSB +: 3]  = clock_source_select;
                next_rdata[WGM_LSB +: 2] = waveform_mode_select;
                next_rdata[COM_LSB +: 2] = compare_output_action;
            end
            ADDR_COUNT: next_rdata[7:0] = timer_count_value;
            ADDR_CMP:   next_rdata[7:0] = pwm ? compare_buffer : compare_value_reg;
            ADDR_FLAGS: begin
                next_rdata[OVF_BIT] = overflow_flag;
                next_rdata[CMP_BIT] = compare_match_flag;
            end
            ADDR_IRQEN: begin
                next_rdata[OVF_BIT] = overflow_irq_enable;
                next_rdata[CMP_BIT] = compare_irq_enable;
                next_rdata[GIE_BIT] = global_irq_enable;
            end
            ADDR_PORT: begin
                next_rdata[PDATA_BIT] = port_data;
                next_rdata[PDIR_BIT]  = compare_pin_direction_bit;
                next_rdata[OCBIT_BIT] = compare_output_bit;
                next_rdata[PIN_BIT]   = pin_sync;
            end
            default: next_err = 1'b1;
        endcase
    end

    // one access cycle, no wait states
    // limitation: read data is frozen at setup, a running count may move on
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= READ_ZERO;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            if (psel && !penable) begin
                prdata <= pwrite ? READ_ZERO : next_rdata;
            end
        end
    end
endmodule

// ### testbench/timer8_sva.sv
// checker on the timer's apb and pin ports
// assumes an apb master that keeps setup then access order
`timescale 1ns/1ps
module timer8_sva
    import timer8_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        compare_irq_ack,
    input wire logic        overflow_irq_ack,
    input wire logic        compare_irq_req,
    input wire logic        overflow_irq_req,
    input wire logic        t0_pin_in,
    input wire logic        oc_pin_in,
    input wire logic        oc_pin_out,
    input wire logic        oc_pin_oe_n
);
    logic setup;
    logic mapped;
    assign setup = psel && !penable;
    assign mapped = paddr inside {ADDR_CTRL, ADDR_COUNT, ADDR_CMP, ADDR_FLAGS, ADDR_IRQEN, ADDR_PORT};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    ready_after_setup_a: assert property (setup |=> pready)
        else $error("pready missing after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped address not refused");
    mapped_ok_a: assert property (setup && mapped |=> !pslverr)
        else $error("mapped address refused");
    unmapped_zero_a: assert property (setup && !mapped && !pwrite |=> prdata == READ_ZERO)
        else $error("unmapped read not zero");
    upper_bits_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    dir_follow_a: assert property (psel && penable && pready && pwrite && paddr == ADDR_PORT
        |=> ##1 oc_pin_oe_n == !$past(pwdata[PDIR_BIT], 2))
        else $error("pin direction not followed");
    cover property (setup && !mapped);
    cover property ($rose(compare_irq_req));
    cover property ($changed(oc_pin_out));
    cover property ($fell(oc_pin_oe_n));
endmodule

bind timer8_compare_normal_ctc timer8_sva u_sva (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
    .t0_pin_in(t0_pin_in), .oc_pin_in(oc_pin_in), .oc_pin_out(oc_pin_out), .oc_pin_oe_n(oc_pin_oe_n)
);

// ### testbench/testbench.sv
// self-checking bench for the 8-bit timer compare unit
// assumes one clock and a pulled-up pin while the timer does not drive it
`timescale 1ns/1ps
module testbench
    import timer8_pkg::*;
;
    logic        clk_sys;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        compare_irq_ack;
    logic        overflow_irq_ack;
    logic        compare_irq_req;
    logic        overflow_irq_req;
    logic        t0_pin_in;
    logic        oc_pin_in;
    logic        oc_pin_out;
    logic        oc_pin_oe_n;
    logic [31:0] rd;
    logic [31:0] pe;
    logic        err;
    logic        exp_oc;
    logic [7:0]  v;
    logic [7:0]  c;
    int          mismatches;
    int          tests_run;
    int          cyc;
    int          scale [1:5] = '{1, 8, 64, 256, 1024};
    logic [1:0]  acts [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};

    assign oc_pin_in = oc_pin_oe_n ? 1'b1 : oc_pin_out;

    timer8_compare_normal_ctc u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
        .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
        .t0_pin_in(t0_pin_in), .oc_pin_in(oc_pin_in), .oc_pin_out(oc_pin_out), .oc_pin_oe_n(oc_pin_oe_n)
    );

    function automatic logic [31:0] cw(input logic [2:0] s, input logic [1:0] m, input logic [1:0] a,
                                       input logic f);
        return (32'(s) << CS_LSB) | (32'(m) << WGM_LSB) | (32'(a) << COM_LSB) | (32'(f) << FORCE_BIT);
    endfunction

    function automatic logic next_oc(input logic [1:0] a, input logic o);
        case (a)
            2'h1: return !o;
            2'h2: return 1'b0;
            2'h3: return 1'b1;
            default: return o;
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // waits for pready as long as it takes; a dead slave is left to the watchdog
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        check("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask

    task automatic wait_flag(input int b);
        for (int k = 0; k < 2000; k++) begin
            apb(1'b0, ADDR_FLAGS, 32'h0);
            if (rd[b] === 1'b1) break;
        end
    endtask

    // counts clock edges between two successive changes of the pin
    task automatic period(output int p);
        logic last;
        int k;
        @(posedge clk_sys);
        last = oc_pin_out;
        for (k = 0; k < 40000 && oc_pin_out === last; k++) @(posedge clk_sys);
        last = oc_pin_out;
        for (p = 1; p < 40000; p++) begin
            @(posedge clk_sys);
            if (oc_pin_out !== last) break;
        end
    endtask

    task automatic end_of_test;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        compare_irq_ack = 1'b0;
        overflow_irq_ack = 1'b0;
        t0_pin_in = 1'b0;
        mismatches = 0;
        tests_run = 0;
        exp_oc = 1'b0;
        void'($urandom(32'h65957e27));
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check("oe_n", 32'h1, {31'h0, oc_pin_oe_n});
        check("pin", 32'h0, {31'h0, oc_pin_out});
        for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0, "reset");
        rd_chk(ADDR_PORT, 32'h1 << PIN_BIT, "port reset");
        apb(1'b1, 8'h18, $urandom);
        check("wr err", 32'h1, {31'h0, err});
        rd_chk(8'h18, READ_ZERO, "unmapped");
        check("rd err", 32'h1, {31'h0, err});
        v = 8'($urandom);
        apb(1'b1, ADDR_COUNT, {24'($urandom), v});
        repeat (20) @(posedge clk_sys);
        rd_chk(ADDR_COUNT, {24'h0, v}, "stopped count");
        apb(1'b1, ADDR_PORT, 32'h1 << PDIR_BIT);
        repeat (3) @(posedge clk_sys);
        check("oe_n on", 32'h0, {31'h0, oc_pin_oe_n});
        foreach (acts[i]) begin
            apb(1'b1, ADDR_CTRL, cw(cs_stop, wgm_normal, acts[i], 1'b1));
            exp_oc = next_oc(acts[i], exp_oc);
            pe = (32'h1 << PDIR_BIT) | (32'(exp_oc) << OCBIT_BIT) | (32'(acts[i] != 2'h0 && exp_oc) << PIN_BIT);
            repeat (4) @(posedge clk_sys);
            check("pin", {31'h0, acts[i] != 2'h0 && exp_oc}, {31'h0, oc_pin_out});
            rd_chk(ADDR_PORT, pe, "out bit");
        end
        rd_chk(ADDR_FLAGS, 32'h0, "force flags");
        rd_chk(ADDR_COUNT, {24'h0, v}, "force count");
        apb(1'b1, ADDR_CTRL, cw(cs_stop, wgm_clear, 2'h0, 1'b0));
        rd_chk(ADDR_PORT, pe, "mode keep");
        c = 8'($urandom);
        apb(1'b1, ADDR_CMP, {24'h0, c});
        apb(1'b1, ADDR_COUNT, {24'h0, c});
        apb(1'b1, ADDR_IRQEN, 32'h1 << CMP_BIT);
        apb(1'b1, ADDR_CTRL, cw(cs_div1, wgm_normal, 2'h0, 1'b0));
        rd_chk(ADDR_FLAGS, 32'(c == COUNT_MAX) << OVF_BIT, "blocked match");
        wait_flag(CMP_BIT);
        check("match flag", 32'h1, {31'h0, rd[CMP_BIT]});
        check("ovf flag", 32'h1, {31'h0, rd[OVF_BIT]});
        apb(1'b1, ADDR_CTRL, cw(cs_stop, wgm_normal, 2'h0, 1'b0));
        check("irq masked", 32'h0, {31'h0, compare_irq_req});
        apb(1'b1, ADDR_IRQEN, 32'h7);
        repeat (3) @(posedge clk_sys);
        check("cmp irq", 32'h1, {31'h0, compare_irq_req});
        check("ovf irq", 32'h1, {31'h0, overflow_irq_req});
        compare_irq_ack <= 1'b1;
        overflow_irq_ack <= 1'b1;
        @(posedge clk_sys);
        compare_irq_ack <= 1'b0;
        overflow_irq_ack <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("irq off", 32'h0, {31'h0, compare_irq_req});
        rd_chk(ADDR_FLAGS, 32'h0, "acked flags");
        apb(1'b1, ADDR_COUNT, {24'h0, c + 8'h01});
        apb(1'b1, ADDR_CTRL, cw(cs_div1, wgm_normal, 2'h0, 1'b0));
        wait_flag(CMP_BIT);
        apb(1'b1, ADDR_CTRL, cw(cs_stop, wgm_normal, 2'h0, 1'b0));
        apb(1'b1, ADDR_FLAGS, 32'h1 << CMP_BIT);
        rd_chk(ADDR_FLAGS, 32'h1 << OVF_BIT, "one clears");
        // clear mode with compare below count must wrap first
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_CTRL, cw(cs_stop, wgm_clear, 2'h0, 1'b0));
        apb(1'b1, ADDR_COUNT, {24'h0, 8'h80 | 8'($urandom)});
        apb(1'b1, ADDR_CMP, {28'h0, 4'($urandom)});
        apb(1'b1, ADDR_CTRL, cw(cs_div1, wgm_clear, 2'h0, 1'b0));
        wait_flag(CMP_BIT);
        check("wrap first", 32'h1, {31'h0, rd[OVF_BIT]});
        // slow prescales get small tops to keep the run short
        for (int s = 1; s <= 5; s++) begin
            c = (s < 3) ? 8'($urandom) : 8'($urandom % 4);
            apb(1'b1, ADDR_CTRL, cw(cs_stop, wgm_clear, com_toggle, 1'b0));
            apb(1'b1, ADDR_COUNT, {24'h0, ~c});
            apb(1'b1, ADDR_CMP, {24'h0, c});
            apb(1'b1, ADDR_CTRL, cw(3'(s), wgm_clear, com_toggle, 1'b0));
            period(cyc);
            check("period", (1 + c) * scale[s], cyc);
        end
        // external count pin, either edge, random number of pulses
        v = 8'($urandom % 9);
        apb(1'b1, ADDR_CTRL, cw(cs_stop, wgm_normal, 2'h0, 1'b0));
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_CTRL, cw(3'(6 + $urandom % 2), wgm_normal, 2'h0, 1'b0));
        repeat (v) begin
            t0_pin_in <= 1'b1;
            repeat (3) @(posedge clk_sys);
            t0_pin_in <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        rd_chk(ADDR_COUNT, {24'h0, v}, "pin count");
        end_of_test();
    end
endmodule
